// ===== data_logging_consts.vh
/*
 Constants for the data-logging control block: register addresses, parameter
 codes, point types, status bit positions, field widths and timing.
 Assumes inclusion by bare name from data_logging_control.v.
*/
// Contract
// (R1) Log type 1 records per reading count, 2 per elapsed seconds.
// (R2) Readings mode: interval is readings between two stored records.
// (R3) Seconds mode: interval is seconds between records; valid 1 to 3600.
// (R4) Overwrite 0 forbids, 1 permits overwriting old records when full.
// (R5) Start mode 0 clears records at start, 1 appends after existing ones.
// (R6) Parameter query returns four zeros when no valid card is fitted.
// (R7) Record query returns timestamp then point data laid out by point type.
// (R8) Input point returns reading in configured units, then status.
// (R9) Input status is an 8-bit flag set, at most 255.
// (R10) Status bits 7..0: off, no curve, s-over, s-zero, t-over, t-under, old, invalid.
// (R11) First output: percent, selector 1 current 2 power, range; second: percent.
// (R12) Record query returns zeros when card absent or logging runs.
// (R13) Point type codes: 0 none, 1 input, 2/3 setpoints, 4/5 outputs.
// (R14) Record query names point 1 to 4 and record 1 to stored count.
// (R15) Log control: 0 stops, 1 starts; query reports running state.
// (R16) Each interval expiry stores one record; full stops unless overwrite.
// (R17) Out-of-range parameter writes are ignored, old settings kept.
`ifndef DATA_LOGGING_CONSTS_VH
`define DATA_LOGGING_CONSTS_VH

// ----------------------------------------
// Register addresses (word index on port)
// ----------------------------------------
`define A_PARAMS 4'h0
`define A_CTRL 4'h1
`define A_COUNT 4'h2
`define A_VIEW_SEL 4'h3
`define A_VIEW_TS 4'h4
`define A_VIEW_D0 4'h5
`define A_VIEW_D1 4'h6
`define A_POINTS 4'h7
`define A_IRQ_STAT 4'h8
`define A_IRQ_MASK 4'h9
`define A_STATE 4'hA

// ----------------------------------------
// Parameter codes
// ----------------------------------------
`define LT_READINGS 2'h1
`define LT_SECONDS 2'h2
`define INTV_MIN 12'h001
`define INTV_MAX 12'hE10
`define PT_NONE 3'h0
`define PT_INPUT 3'h1
`define PT_SP1 3'h2
`define PT_SP2 3'h3
`define PT_FIRST_OUTPUT 3'h4
`define PT_SECOND_OUTPUT 3'h5
`define PT_LAST 3'h5
`define SEL_CURRENT 2'h1
`define SEL_POWER 2'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define F_LT_LO 0
`define F_IV_LO 4
`define F_OW 16
`define F_SM 17
`define F_PT_W 4
`define IRQ_REC 0
`define IRQ_FULL 1
`define IRQ_WRAP 2

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define MEM_DEPTH 256
`define ADDR_W 8
`define CNT_W 9
`define REC_W 128
`define SYS_HZ 250000000
`define SEC_CYCLES (`SYS_HZ)
`define ZERO32 32'h0000_0000

`endif

// ===== interval_timer.v
/*
 Interval timer: counts readings or seconds and pulses once per interval.
 Assumes reading_tick is a one-cycle pulse in the sys_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "data_logging_consts.vh"

module interval_timer #(
	parameter SEC_CYC = `SEC_CYCLES
)(
	input wire sys_clk,
	input wire srst,
	input wire run,
	input wire [1:0] log_type,
	input wire [11:0] interval,
	input wire reading_tick,
	output reg expire_q
);

// ----------------------------------------
// Tick sources and interval count
// ----------------------------------------
reg [27:0] sec_cnt_q;
reg [11:0] ev_cnt_q;
wire sec_tick;
wire ev;

assign sec_tick = (sec_cnt_q == SEC_CYC - 1);
// Choose reading or second events
assign ev = (log_type == `LT_READINGS) ? reading_tick : sec_tick; // see (R1)

// Prescaler and event counter; both rest while logging is stopped
always @(posedge sys_clk)
begin
	if (srst || !run)
	begin
		sec_cnt_q <= 28'h000_0000;
		ev_cnt_q <= 12'h000;
		expire_q <= 1'b0;
	end
	else
	begin
		sec_cnt_q <= sec_tick ? 28'h000_0000 : sec_cnt_q + 28'h000_0001;
		expire_q <= 1'b0;
		if (ev)
		begin
			// Interval of N events gives one record each N events
			if (ev_cnt_q + 12'h001 >= interval) // see (R2) see (R3)
			begin
				ev_cnt_q <= 12'h000;
				expire_q <= 1'b1;
			end
			else
				ev_cnt_q <= ev_cnt_q + 12'h001;
		end
	end
end

endmodule
`default_nettype wire

// ===== data_logging_control.v
/*
 Data-logging control: parameter and point configuration, run control,
 record store in a local array, record view and interrupt status.
 Assumes a same-clock register port; card_present arrives from a pin.
*/
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "data_logging_consts.vh"

module data_logging_control #(
	parameter SEC_CYC = `SEC_CYCLES
)(
	input wire sys_clk,
	input wire srst,
	input wire [3:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata_q,
	input wire card_present,
	input wire reading_tick,
	input wire [31:0] timestamp,
	input wire [31:0] input_reading,
	input wire [7:0] input_status,
	input wire [31:0] sp1_value,
	input wire [31:0] sp2_value,
	input wire [15:0] first_output_pct,
	input wire [1:0] first_output_sel,
	input wire [7:0] first_output_range,
	input wire [15:0] second_output_pct,
	output wire irq,
	output wire logging
);

// ----------------------------------------
// State
// ----------------------------------------
localparam S_IDLE = 2'b01;
localparam S_RUN = 2'b10;

reg [1:0] state_q;
reg [1:0] log_type_q;
reg [11:0] interval_q;
reg overwrite_q;
reg start_mode_q;
reg [11:0] point_cfg_q;
reg [`CNT_W-1:0] count_q;
reg [`ADDR_W-1:0] wptr_q;
reg [`ADDR_W-1:0] view_rec_q;
reg [1:0] view_pt_q;
reg [2:0] irq_stat_q;
reg [2:0] irq_mask_q;
reg card_s1_q;
reg card_s2_q;
reg [`REC_W-1:0] mem [0:`MEM_DEPTH-1];
reg [`REC_W-1:0] view_q;

wire running;
wire expire;
wire full;
wire store;
reg wr_params;
reg wr_ctrl;
reg wr_points;
reg wr_view;
reg wr_irq_stat;
reg wr_irq_mask;
wire [1:0] w_lt;
wire [11:0] w_iv;
wire params_ok;
wire points_ok;
wire [`REC_W-1:0] rec_d;
wire [2:0] ev_set;

assign running = state_q[1];
assign logging = running;

// ----------------------------------------
// Card presence synchroniser
// ----------------------------------------
// Pin is asynchronous to sys_clk; two flops before any use
always @(posedge sys_clk)
begin
	if (srst)
	begin
		card_s1_q <= 1'b0;
		card_s2_q <= 1'b0;
	end
	else
	begin
		card_s1_q <= card_present;
		card_s2_q <= card_s1_q; // Only this flop reads the first stage
	end
end

// ----------------------------------------
// Write decode and range checks
// ----------------------------------------
// One strobe per register; nothing decodes while wr is low
always @*
begin
	wr_params = 1'b0;
	wr_ctrl = 1'b0;
	wr_points = 1'b0;
	wr_view = 1'b0;
	wr_irq_stat = 1'b0;
	wr_irq_mask = 1'b0;
	if (wr)
	begin
		if (addr == `A_PARAMS)
			wr_params = 1'b1;
		else if (addr == `A_CTRL)
			wr_ctrl = 1'b1;
		else if (addr == `A_POINTS)
			wr_points = 1'b1;
		else if (addr == `A_VIEW_SEL)
			wr_view = 1'b1;
		else if (addr == `A_IRQ_STAT)
			wr_irq_stat = 1'b1;
		else if (addr == `A_IRQ_MASK)
			wr_irq_mask = 1'b1;
	end
end
assign w_lt = wdata[`F_LT_LO+1:`F_LT_LO];
assign w_iv = wdata[`F_IV_LO+11:`F_IV_LO];
// Whole write dropped if any field is out of range
assign params_ok = ((w_lt == `LT_READINGS) || (w_lt == `LT_SECONDS))
	&& (w_iv >= `INTV_MIN) && (w_iv <= `INTV_MAX); // see (R1) see (R3) see (R17)

// Every point type must be a known code
genvar g;
wire [3:0] pt_ok;
generate
	for (g = 0; g < 4; g = g + 1)
	begin : g_pt
		assign pt_ok[g] = (wdata[g*`F_PT_W+2:g*`F_PT_W] <= `PT_LAST); // see (R13)
	end
endgenerate
assign points_ok = &pt_ok;

// ----------------------------------------
// Interval timer
// ----------------------------------------
interval_timer #(
	.SEC_CYC(SEC_CYC)
) u_timer (
	.sys_clk(sys_clk),
	.srst(srst),
	.run(running),
	.log_type(log_type_q),
	.interval(interval_q),
	.reading_tick(reading_tick),
	.expire_q(expire)
);

assign full = (count_q == `MEM_DEPTH);
// Full memory blocks storing unless overwrite is on
assign store = running && expire && card_s2_q && (!full || overwrite_q); // see (R4) see (R16)

// ----------------------------------------
// Record snapshot
// ----------------------------------------
// Layout: [127:96] timestamp, then one 24-bit field per point
function [23:0] pt_data;
	input [2:0] t;
	begin
		case (t)
			`PT_INPUT: pt_data = {input_reading[15:0], input_status}; // see (R8) see (R9) see (R10)
			`PT_SP1: pt_data = sp1_value[23:0];
			`PT_SP2: pt_data = sp2_value[23:0];
			`PT_FIRST_OUTPUT: pt_data = {first_output_pct[13:0], first_output_sel, first_output_range}; // see (R11)
			`PT_SECOND_OUTPUT: pt_data = {8'h00, second_output_pct};
			default: pt_data = 24'h00_0000;
		endcase
	end
endfunction

assign rec_d = {timestamp,
	pt_data(point_cfg_q[11:9]), pt_data(point_cfg_q[8:6]),
	pt_data(point_cfg_q[5:3]), pt_data(point_cfg_q[2:0])}; // see (R7)

// ----------------------------------------
// Configuration, run control and store
// ----------------------------------------
always @(posedge sys_clk)
begin
	if (srst)
	begin
		state_q <= S_IDLE;
		log_type_q <= `LT_READINGS;
		interval_q <= `INTV_MIN;
		overwrite_q <= 1'b0;
		start_mode_q <= 1'b0;
		point_cfg_q <= 12'h000;
		count_q <= 9'h000;
		wptr_q <= 8'h00;
		view_rec_q <= 8'h00;
		view_pt_q <= 2'h0;
	end
	else
	begin
		if (wr_params && params_ok)
		begin
			log_type_q <= w_lt;
			interval_q <= w_iv;
			overwrite_q <= wdata[`F_OW];
			start_mode_q <= wdata[`F_SM];
		end
		// A single unknown type drops the whole point write
		if (wr_points && points_ok)
			point_cfg_q <= {wdata[14:12], wdata[10:8], wdata[6:4], wdata[2:0]};
		// Record view: point 1..4 and record 1..count, stored zero-based
		if (wr_view && (wdata[9:8] <= 2'h3)
			&& (wdata[`ADDR_W-1:0] < count_q)) // see (R14)
		begin
			view_rec_q <= wdata[`ADDR_W-1:0];
			view_pt_q <= wdata[9:8];
		end
		case (state_q)
			S_IDLE:
			begin
				if (wr_ctrl && wdata[0] && card_s2_q) // see (R15)
				begin
					state_q <= S_RUN;
					if (!start_mode_q) // see (R5)
					begin
						count_q <= 9'h000;
						wptr_q <= 8'h00;
					end
				end
			end
			S_RUN:
			begin
				if ((wr_ctrl && !wdata[0]) || !card_s2_q)
					state_q <= S_IDLE;
				if (store)
				begin
					wptr_q <= wptr_q + 8'h01;
					if (!full)
						count_q <= count_q + 9'h001;
				end
			end
			default: state_q <= S_IDLE;
		endcase
	end
end

// Record array write and registered read of the selected record
always @(posedge sys_clk)
begin
	if (store)
		mem[wptr_q] <= rec_d;
	view_q <= mem[view_rec_q];
end

// ----------------------------------------
// Interrupt status and mask
// ----------------------------------------
assign ev_set = {store && full, store && (count_q == `MEM_DEPTH - 1), store};

// Set wins over a write-one clear in the same cycle
always @(posedge sys_clk)
begin
	if (srst)
	begin
		irq_stat_q <= 3'h0;
		irq_mask_q <= 3'h0;
	end
	else
	begin
		if (wr_irq_stat)
			irq_stat_q <= (irq_stat_q & ~wdata[2:0]) | ev_set;
		else
			irq_stat_q <= irq_stat_q | ev_set;
		if (wr_irq_mask)
			irq_mask_q <= wdata[2:0];
	end
end

assign irq = |(irq_stat_q & irq_mask_q);

// ----------------------------------------
// Read data
// ----------------------------------------
wire view_blank;
reg [23:0] view_pt;
// Zeros while logging runs or card missing
// Point type read back is the live setting, not the one at store time
assign view_blank = running || !card_s2_q; // see (R12)

always @*
begin
	case (view_pt_q)
		2'h0: view_pt = view_q[23:0];
		2'h1: view_pt = view_q[47:24];
		2'h2: view_pt = view_q[71:48];
		default: view_pt = view_q[95:72];
	endcase
end

// Read data stands one cycle after the strobe, zero otherwise
always @(posedge sys_clk)
begin
	if (srst || !rd)
		rdata_q <= `ZERO32;
	else if (addr == `A_PARAMS)
		rdata_q <= card_s2_q ? {14'h0000, start_mode_q, overwrite_q, interval_q,
			2'h0, log_type_q} : `ZERO32; // see (R6)
	else if (addr == `A_CTRL)
		rdata_q <= {31'h0000_0000, running}; // see (R15)
	else if (addr == `A_COUNT)
		rdata_q <= {23'h00_0000, count_q};
	else if (addr == `A_VIEW_SEL)
		rdata_q <= {22'h00_0000, view_pt_q, view_rec_q};
	else if (addr == `A_VIEW_TS)
		rdata_q <= view_blank ? `ZERO32 : view_q[127:96]; // see (R7) see (R12)
	else if (addr == `A_VIEW_D0)
		rdata_q <= view_blank ? `ZERO32 : {8'h00, view_pt};
	else if (addr == `A_VIEW_D1)
		rdata_q <= view_blank ? `ZERO32 : {29'h0000_0000, point_cfg_q[view_pt_q*3 +: 3]};
	else if (addr == `A_POINTS)
		rdata_q <= {16'h0000, 1'b0, point_cfg_q[11:9], 1'b0, point_cfg_q[8:6],
			1'b0, point_cfg_q[5:3], 1'b0, point_cfg_q[2:0]};
	else if (addr == `A_IRQ_STAT)
		rdata_q <= {29'h0000_0000, irq_stat_q};
	else if (addr == `A_IRQ_MASK)
		rdata_q <= {29'h0000_0000, irq_mask_q};
	else if (addr == `A_STATE)
		rdata_q <= {28'h000_0000, wptr_q[0], card_s2_q, state_q};
	else
		rdata_q <= `ZERO32;
end

endmodule
`default_nettype wire

// ===== data_logging_checker.sv
/* Port checker for data_logging_control.
 Assumes the bind below and read data one cycle after rd. */
`timescale 1ns/1ps
`default_nettype none
module data_logging_checker #(
	parameter SEC_CYC = 10
)(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata_q,
	input wire logic card_present,
	input wire logic irq,
	input wire logic logging
);
	// ----------
	// Port rules
	// ----------
	localparam logic [31:0] zw = 32'h0000_0000;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	// Four samples low so the synchroniser has caught up
	sequence gone;
		(!card_present) [*4];
	endsequence
	idle_zero_a: assert property (!$past(rd) |-> rdata_q == zw)
		else $error("read data outside read slot");
	param_gone_a: assert property (gone ##0 (rd && addr == 4'h0) |=> rdata_q == zw)
		else $error("params shown without card");
	view_gone_a: assert property (gone ##0 (rd && addr inside {4'h4, 4'h5, 4'h6})
		|=> rdata_q == zw)
		else $error("record shown without card");
	view_busy_a: assert property (logging && rd && addr inside {4'h4, 4'h5, 4'h6}
		|=> rdata_q == zw)
		else $error("record shown while logging");
	start_gone_a: assert property (gone ##0 !logging |=> !logging)
		else $error("logging without card");
	start_ok_a: assert property (card_present [*4] ##0
		(wr && addr == 4'h1 && wdata[0]) |=> logging)
		else $error("start not taken");
	stop_now_a: assert property (wr && addr == 4'h1 && !wdata[0] |=> !logging)
		else $error("stop not taken");
	param_legal_a: assert property (rd && addr == 4'h0 |=> (rdata_q == zw
		|| (rdata_q[15:4] != 12'h000 && rdata_q[15:4] <= 12'hE10
		&& rdata_q[1:0] inside {2'h1, 2'h2})))
		else $error("illegal params held");
	mask_off_a: assert property (wr && addr == 4'h9 && wdata[2:0] == 3'h0 |=> !irq)
		else $error("masked irq raised");
	cover property (wr && addr == 4'h1 && wdata[0] ##1 logging);
	cover property (irq);
	cover property (rd && addr == 4'h5 && !logging);
endmodule
bind data_logging_control data_logging_checker #(.SEC_CYC(SEC_CYC)) chk (.sys_clk(sys_clk),
	.srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
	.card_present(card_present), .irq(irq), .logging(logging));
`default_nettype wire

// ===== log_host.sv
/* Host model: register master of the logging block.
 Assumes one-cycle strobes and read data in the next cycle. */
`timescale 1ns/1ps
`default_nettype none
module log_host (
	input wire logic sys_clk,
	input wire logic [31:0] rdata_q,
	output var logic [3:0] addr,
	output var logic [31:0] wdata,
	output var logic wr,
	output var logic rd
);
	// ----------
	// Bus cycles
	// ----------
	initial
	begin
		addr = 4'h0;
		wdata = 32'h0000_0000;
		wr = 1'b0;
		rd = 1'b0;
	end
	// Lines flip on release so stale values never pass for valid
	task automatic put(input logic [3:0] a, input logic [31:0] v);
	begin
		@(posedge sys_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~v;
		// Return once the write has landed so callers see its effect
		#1;
	end
	endtask
	// Data taken only in the slot after the strobe
	task automatic get(input logic [3:0] a, output logic [31:0] v);
	begin
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		addr <= ~a;
		#1;
		v = rdata_q;
	end
	endtask
endmodule
`default_nettype wire

// ===== tb_data_logging_control.sv
/* Testbench for data_logging_control.
 Assumes log_host and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_data_logging_control;
	logic sys_clk;
	logic srst;
	logic card_present;
	logic reading_tick;
	logic [31:0] timestamp, input_reading, sp1_value, sp2_value;
	logic [7:0] input_status, first_output_range;
	logic [15:0] first_output_pct, second_output_pct;
	logic [1:0] first_output_sel;
	logic [3:0] addr;
	logic [31:0] wdata, rdata_q, d, w, v, cur;
	logic wr, rd, irq, logging;
	logic [31:0] saved [0:99];
	logic [31:0] pv [0:3] = '{32'h0000_E102, 32'h0000_E112, 32'h0000_0002, 32'h0003_0011};
	integer seed, miscompares, n_compared, cyc;
	data_logging_control #(.SEC_CYC(10)) uut (.sys_clk(sys_clk), .srst(srst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .card_present(card_present),
		.reading_tick(reading_tick), .timestamp(timestamp), .input_reading(input_reading),
		.input_status(input_status), .sp1_value(sp1_value), .sp2_value(sp2_value),
		.first_output_pct(first_output_pct), .first_output_sel(first_output_sel), .first_output_range(first_output_range),
		.second_output_pct(second_output_pct), .irq(irq), .logging(logging));
	log_host host (.sys_clk(sys_clk), .rdata_q(rdata_q), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd));
	// -------------
	// Clock and helpers
	// -------------
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Hang guard, far above the expected run
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			miscompares = miscompares + 1;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_compared = n_compared + 1;
		if (got !== exp)
		begin
			miscompares = miscompares + 1;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task automatic final_report;
	begin
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	// Live values held steady long enough for the store to sample them
	task automatic ticks(input int n);
		for (int k = 0; k < n; k++)
		begin
			@(posedge sys_clk);
			w = $random(seed);
			timestamp <= w;
			input_reading <= ~w;
			input_status <= w[7:0];
			sp1_value <= {w[15:0], w[31:16]};
			sp2_value <= w;
			first_output_pct <= w[15:0];
			first_output_sel <= w[0] ? 2'h1 : 2'h2;
			first_output_range <= w[31:24];
			second_output_pct <= w[31:16];
			reading_tick <= 1'b1;
			@(posedge sys_clk);
			reading_tick <= 1'b0;
			repeat (3) @(posedge sys_clk);
			if (k % 3 == 2)
				saved[k / 3] = w;
		end
	endtask
	// Points 1..4 are input, first setpoint, first output, second output
	function automatic logic [31:0] expd(input logic [31:0] x, input logic [1:0] p);
		case (p)
			2'h0: expd = {8'h00, ~x[15:0], x[7:0]};
			2'h1: expd = {8'h00, x[7:0], x[31:16]};
			2'h2: expd = {8'h00, x[13:0], (x[0] ? 2'h1 : 2'h2), x[31:24]};
			default: expd = {16'h0000, x[31:16]};
		endcase
	endfunction
	// ---------
	// Scenarios
	// ---------
	initial
	begin
		{seed, miscompares, n_compared, cyc} = {32'd80, 96'd0};
		{srst, card_present, reading_tick} = 3'b100;
		{timestamp, input_reading, sp1_value, sp2_value} = 128'h0;
		{input_status, first_output_range, first_output_pct, second_output_pct, first_output_sel} = 50'h0;
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		host.get(4'h0, d);
		chk(d, 32'h0000_0000);
		host.get(4'h5, d);
		chk(d, 32'h0000_0000);
		host.put(4'h1, 32'h0000_0001);
		chk({31'h0, logging}, 32'h0000_0000);
		@(posedge sys_clk);
		card_present <= 1'b1;
		repeat (3) @(posedge sys_clk);
		cur = 32'h0000_0011;
		for (int i = 0; i < 12; i++)
		begin
			v = i < 4 ? pv[i] : $random(seed) & 32'h0003_FFF3;
			host.put(4'h0, v);
			if (v[1:0] inside {2'h1, 2'h2} && v[15:4] != 0 && v[15:4] <= 12'hE10)
				cur = v;
			host.get(4'h0, d);
			chk(d, cur);
		end
		foreach (pv[i])
		begin
			v = i == 1 ? 32'h0000_0006 : i == 3 ? 32'h0000_5421 : 32'h0000_0003;
			host.put(4'h7, v);
			host.get(4'h7, d);
			chk(d, i == 1 ? 32'h0000_0003 : v);
		end
		$display("config done");
		host.put(4'h0, 32'h0000_0031);
		host.put(4'h9, 32'h0000_0001);
		host.put(4'h1, 32'h0000_0001);
		ticks(6);
		host.get(4'h4, d);
		chk(d, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0001);
		host.put(4'h9, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		host.put(4'h1, 32'h0000_0000);
		host.get(4'h2, d);
		chk(d, 32'h0000_0002);
		host.put(4'h8, 32'h0000_0007);
		host.get(4'h8, d);
		chk(d, 32'h0000_0000);
		for (int r = 0; r < 2; r++)
			for (int p = 0; p < 4; p++)
			begin
				host.put(4'h3, {22'h00_0000, p[1:0], r[7:0]});
				host.get(4'h4, d);
				chk(d, saved[r]);
				host.get(4'h5, d);
				chk(d, expd(saved[r], p[1:0]));
				host.get(4'h6, d);
				chk(d, (32'h0000_5421 >> (4 * p)) & 32'h0000_0007);
			end
		host.put(4'h3, 32'h0000_0002);
		host.get(4'h4, d);
		chk(d, saved[1]);
		$display("readings done");
		host.put(4'h0, 32'h0002_0022);
		host.put(4'h1, 32'h0000_0001);
		repeat (90) @(posedge sys_clk);
		host.put(4'h1, 32'h0000_0000);
		host.get(4'h2, d);
		chk(d, 32'h0000_0006);
		host.put(4'h0, 32'h0000_0011);
		host.put(4'h1, 32'h0000_0001);
		host.put(4'h1, 32'h0000_0000);
		host.get(4'h2, d);
		chk(d, 32'h0000_0000);
		$display("seconds done");
		host.put(4'h1, 32'h0000_0001);
		ticks(260);
		host.get(4'h2, d);
		chk(d, 32'h0000_0100);
		host.get(4'h8, d);
		chk(d & 32'h0000_0006, 32'h0000_0002);
		host.put(4'h1, 32'h0000_0000);
		host.put(4'h0, 32'h0003_0011);
		host.put(4'h1, 32'h0000_0001);
		ticks(2);
		host.get(4'h8, d);
		chk(d & 32'h0000_0004, 32'h0000_0004);
		@(posedge sys_clk);
		card_present <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk({31'h0, logging}, 32'h0000_0000);
		host.get(4'h0, d);
		chk(d, 32'h0000_0000);
		$display("full done");
		// Reset after the card-loss stop must bring back the defaults
		@(posedge sys_clk);
		srst <= 1'b1;
		card_present <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		host.get(4'h0, d);
		chk(d, 32'h0000_0011);
		host.get(4'h8, d);
		chk(d, 32'h0000_0000);
		chk({31'h0, logging}, 32'h0000_0000);
		$display("reset done");
		final_report;
	end
endmodule
`default_nettype wire
